// ---- hdl/flash_cfg.svh ----
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH
// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define OFS_STATUS    32'hfffff800
`define OFS_MODE      32'hfffff804
`define OFS_CMD       32'hfffff808
`define OFS_DATA      32'hfffff80c
`define OFS_ADDR      32'hfffff810
`define OFS_SIGN      32'hfffff818
`define OFS_PPRO      32'hfffff81c
`define OFS_IPRO      32'hfffff820
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MODE_KEY_EN   6
`define MODE_KEY_SEL  5
`define MODE_IRQ_EN   4
`define MODE_EW_EN    3
`define ST_IRQ        3
`define ST_BUSY       2
`define ST_FAIL       1
`define ST_PASS       0
`define PRO_READ      31
// ----------------------------------------------------------------------
// reset values and keys
// ----------------------------------------------------------------------
`define RST_MODE      16'h0000
`define RST_CMD       8'h07
`define RST_DATA      16'h0000
`define RST_ADDR      16'h0000
`define RST_SIGN      24'hffffff
`define RST_PPRO      32'h00000000
`define RST_IPRO      32'h0fffffff
`define OPEN_PRO      32'hffffffff
`define MASS_DATA_KEY 16'h3cff
`define MASS_ADDR_KEY 16'hffc3
`define PERM_KEY      32'hdeaddead
`define ERASED_WORD   16'hffff
// ----------------------------------------------------------------------
// geometry and timing
// ----------------------------------------------------------------------
`define PAGE_WORDS    32'd256
`define USER_WORDS    32'd31744
`define KERNEL_GROUP  5'h1f
`define CLK_MHZ       200
`define WRITE_TIME_US 50
`define EW_TIME_MS    24
`define MASS_TIME_MS  2480
`define WRITE_CYCLES  (`WRITE_TIME_US * `CLK_MHZ)
`define EW_CYCLES     (`EW_TIME_MS * 1000 * `CLK_MHZ)
`define MASS_CYCLES   (`MASS_TIME_MS * 1000 * `CLK_MHZ)
`define SIGN_CYCLES   32778
`endif

// ---- hdl/flash_pkg.sv ----
package flash_pkg;
  // controller states, gray along idle-wait-erase-prog
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WAIT  = 3'h1,
    ST_ERASE = 3'h3,
    ST_PROG  = 3'h2,
    ST_READ  = 3'h6,
    ST_SIGN  = 3'h7,
    ST_DONE  = 3'h5
  } state_t;
  // command codes
  typedef enum logic [7:0] {
    CMD_NULL    = 8'h00,
    CMD_READ    = 8'h01,
    CMD_WRITE   = 8'h02,
    CMD_EWRITE  = 8'h03,
    CMD_VERIFY  = 8'h04,
    CMD_ERASE   = 8'h05,
    CMD_MASS    = 8'h06,
    CMD_SIGN    = 8'h0b,
    CMD_PROTECT = 8'h0c,
    CMD_PING    = 8'h0f
  } cmd_t;
endpackage : flash_pkg

// ---- hdl/flash_store.sv ----
`timescale 1ns/1ps
module flash_store #(
  parameter int unsigned AW = 15,
  parameter int unsigned DW = 16
) (
  // clock
  input  wire logic          clock,
  // access port
  input  wire logic [AW-1:0] addr,
  input  wire logic          wrEn,
  input  wire logic [DW-1:0] wrData,
  output logic      [DW-1:0] rdData
);
  // word array
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------------------------------------
  // write and registered read
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (wrEn)
    begin
      mem[addr] <= wrData;
    end
    rdData <= mem[addr];
  end
endmodule : flash_store

// ---- hdl/flash_command_controller.sv ----
// Functional notes
// - interrupt on completion when mode bit 4
// - erase and write need mode bit 3
// - command reads 0x07 after codes 0-6
// - code 0x01 loads data from flash
// - code 0x02 programs word, 50 us
// - code 0x03 erases page, programs, 24 ms
// - code 0x04 compares, result in status
// - code 0x05 erases addressed page only
// - code 0x06 mass erase, kernel kept
// - code 0x0B signature over flash, 32778 cycles
// - code 0x0C saves protection, key guarded
// - code 0x0F only completes, interrupt when mode bit 4
// - data and address registers 16 bits
// - signature read only, resets all ones
// - persistent protection active after reset
// - immediate protection acts at once
// - bit 31 allows code reading
// - bits 30-0 allow writing page groups
// - each group four pages, checked by codes 0x02, 0x03, 0x05
// - status bits, read clears 3,1,0
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "flash_cfg.svh"
module flash_command_controller #(
  parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES,
  parameter int unsigned EW_CYCLES    = `EW_CYCLES,
  parameter int unsigned MASS_CYCLES  = `MASS_CYCLES,
  parameter int unsigned SIGN_CYCLES  = `SIGN_CYCLES
) (
  // clock and resets
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        powerOnRst_n,
  // register port
  input  wire logic [31:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  // status outputs
  output logic             flashIrq,
  output logic             readLocked
);
  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (WRITE_CYCLES < 1 || EW_CYCLES < 1 || MASS_CYCLES < 1)
  begin : g_chk_time
    $error("timed command counts must be at least one");
  end
  if (SIGN_CYCLES < 32770)
  begin : g_chk_sign
    $error("signature count must cover the whole array");
  end

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  flash_pkg::state_t state_ff;    // controller state
  flash_pkg::state_t nxt_state;   // next state
  flash_pkg::cmd_t   op_ff;       // running command
  logic [31:0] cnt_ff;            // wait, erase and signature counter
  logic        result_ff;         // pass decided at start
  logic        startPass;         // pass decided in idle
  logic [15:0] mode_ff;           // mode control
  logic [7:0]  cmd_ff;            // command readback
  logic [15:0] data_ff;           // data register
  logic [15:0] addr_ff;           // address register
  logic [23:0] sign_ff;           // signature result
  logic [23:0] sigAcc_ff;         // signature accumulator
  logic [31:0] ppro_ff;           // persistent protection as written
  logic [31:0] ipro_ff;           // immediate protection
  logic [31:0] savedPro_ff;       // saved persistent value
  logic [31:0] savedKey_ff;       // saved key
  logic        keySet_ff;         // a key has been saved
  logic [31:0] activePro_ff;      // persistent protection in force
  logic        irqPend_ff;        // interrupt pending
  logic        fail_ff;           // command fail
  logic        pass_ff;           // command pass
  logic        readLocked_ff;     // code read blocked
  logic [31:0] rdData_ff;         // read data
  logic [14:0] memAddr;           // array word address
  logic        memWe;             // array write
  logic [15:0] memWd;             // array write data
  logic [15:0] memRd;             // array read data
  logic        start;             // command write in idle
  logic        done;              // completion cycle
  logic        donePass;          // completion outcome
  logic        statusRead;        // status read strobe
  logic [31:0] keyIn;             // key presented
  logic        keyOk;             // protect command allowed
  logic        grpOk;             // addressed group writable
  logic [31:0] waitLen;           // timed part length
  logic [31:0] eraseLen;          // erase loop length

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // writable when both masks allow the group and it is not the kernel
  function automatic logic groupWritable(input logic [15:0] a, input logic [31:0] m);
    logic [4:0] grp;
    grp = a[15:11];
    groupWritable = (grp != `KERNEL_GROUP) && m[grp];
  endfunction : groupWritable

  // one signature step: rotate and fold in a word
  function automatic logic [23:0] sigStep(input logic [23:0] s, input logic [15:0] w);
    sigStep = {s[22:0], s[23]} ^ {8'h00, w};
  endfunction : sigStep

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  assign start      = regWrite && (regAddr == `OFS_CMD) && (state_ff == flash_pkg::ST_IDLE);
  assign statusRead = regRead && (regAddr == `OFS_STATUS);
  assign done       = (state_ff == flash_pkg::ST_DONE);
  assign keyIn      = {addr_ff, data_ff};
  assign grpOk      = groupWritable(addr_ff, activePro_ff & ipro_ff);
  assign keyOk      = mode_ff[`MODE_KEY_EN] && !mode_ff[`MODE_KEY_SEL]
                      && (!keySet_ff || (keyIn == savedKey_ff && savedKey_ff != `PERM_KEY));
  assign donePass   = (op_ff == flash_pkg::CMD_VERIFY) ? (memRd == data_ff) : result_ff;

  // timed length of the running command
  always_comb
  begin
    unique case (op_ff)
      flash_pkg::CMD_WRITE:  waitLen = WRITE_CYCLES;
      flash_pkg::CMD_EWRITE: waitLen = EW_CYCLES;
      flash_pkg::CMD_MASS:   waitLen = MASS_CYCLES;
      default:               waitLen = 32'd1;
    endcase
    eraseLen = (op_ff == flash_pkg::CMD_MASS) ? `USER_WORDS : `PAGE_WORDS;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    startPass = 1'b1;
    unique case (state_ff)
      flash_pkg::ST_IDLE:
      begin
        if (start)
        begin
          unique case (regWrData[7:0])
            flash_pkg::CMD_READ, flash_pkg::CMD_VERIFY:
              nxt_state = flash_pkg::ST_READ;
            flash_pkg::CMD_WRITE, flash_pkg::CMD_EWRITE, flash_pkg::CMD_ERASE:
            begin
              if (mode_ff[`MODE_EW_EN] && grpOk)
                nxt_state = flash_pkg::ST_WAIT;
              else
              begin
                nxt_state = flash_pkg::ST_DONE;
                startPass = 1'b0;
              end
            end
            flash_pkg::CMD_MASS:
            begin
              if (mode_ff[`MODE_EW_EN] && data_ff == `MASS_DATA_KEY
                  && addr_ff == `MASS_ADDR_KEY)
                nxt_state = flash_pkg::ST_WAIT;
              else
              begin
                nxt_state = flash_pkg::ST_DONE;
                startPass = 1'b0;
              end
            end
            flash_pkg::CMD_SIGN:
              nxt_state = flash_pkg::ST_SIGN;
            flash_pkg::CMD_PROTECT:
            begin
              nxt_state = flash_pkg::ST_DONE;
              startPass = keyOk;
            end
            flash_pkg::CMD_PING:
              nxt_state = flash_pkg::ST_DONE;
            default:
              nxt_state = flash_pkg::ST_IDLE;
          endcase
        end
      end
      // timed part, then program or erase
      flash_pkg::ST_WAIT:
      begin
        if (cnt_ff == waitLen - 32'd1)
          nxt_state = (op_ff == flash_pkg::CMD_WRITE) ? flash_pkg::ST_PROG
                                                      : flash_pkg::ST_ERASE;
      end
      // erase one word per cycle
      flash_pkg::ST_ERASE:
      begin
        if (cnt_ff == eraseLen - 32'd1)
          nxt_state = (op_ff == flash_pkg::CMD_EWRITE) ? flash_pkg::ST_PROG
                                                       : flash_pkg::ST_DONE;
      end
      flash_pkg::ST_PROG: nxt_state = flash_pkg::ST_DONE;
      flash_pkg::ST_READ: nxt_state = flash_pkg::ST_DONE;
      flash_pkg::ST_SIGN:
      begin
        if (cnt_ff == SIGN_CYCLES - 32'd1)
          nxt_state = flash_pkg::ST_DONE;
      end
      flash_pkg::ST_DONE: nxt_state = flash_pkg::ST_IDLE;
      default:            nxt_state = flash_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------------
  // state, command, counter
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_ff  <= flash_pkg::ST_IDLE;
      op_ff     <= flash_pkg::CMD_NULL;
      cnt_ff    <= 32'h00000000;
      result_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= (nxt_state != state_ff) ? 32'h00000000 : cnt_ff + 32'd1;
      if (start)
      begin
        op_ff     <= flash_pkg::cmd_t'(regWrData[7:0]);
        result_ff <= startPass;
      end
    end
  end

  // ----------------------------------------------------------------------
  // flash array access
  // ----------------------------------------------------------------------
  always_comb
  begin
    memAddr = addr_ff[15:1];
    memWe   = 1'b0;
    memWd   = data_ff;
    unique case (state_ff)
      flash_pkg::ST_ERASE:
      begin
        memWe   = 1'b1;
        memWd   = `ERASED_WORD;
        memAddr = (op_ff == flash_pkg::CMD_MASS) ? cnt_ff[14:0]
                                                 : {addr_ff[15:9], cnt_ff[7:0]};
      end
      flash_pkg::ST_PROG: memWe = 1'b1;
      flash_pkg::ST_SIGN: memAddr = cnt_ff[14:0];
      default:            memAddr = addr_ff[15:1];
    endcase
  end

  flash_store #(
    .AW (15),
    .DW (16)
  ) u_store (
    .clock  (clock),
    .addr   (memAddr),
    .wrEn   (memWe),
    .wrData (memWd),
    .rdData (memRd)
  );

  // signature accumulation, one cycle behind the address
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sigAcc_ff <= `RST_SIGN;
      sign_ff   <= `RST_SIGN;
    end
    else if (start)
      sigAcc_ff <= `RST_SIGN;
    else if (state_ff == flash_pkg::ST_SIGN && cnt_ff >= 32'd1 && cnt_ff <= 32'd32768)
      sigAcc_ff <= sigStep(sigAcc_ff, memRd);
    else if (done && op_ff == flash_pkg::CMD_SIGN)
      sign_ff <= sigAcc_ff;
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  // mode, address, data
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mode_ff <= `RST_MODE;
      addr_ff <= `RST_ADDR;
      data_ff <= `RST_DATA;
    end
    else
    begin
      if (regWrite && regAddr == `OFS_MODE)
        mode_ff <= regWrData[15:0];
      if (regWrite && regAddr == `OFS_ADDR)
        addr_ff <= regWrData[15:0];
      if (done && op_ff == flash_pkg::CMD_READ)
        data_ff <= memRd;
      else if (regWrite && regAddr == `OFS_DATA)
        data_ff <= regWrData[15:0];
    end
  end

  // command readback
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cmd_ff <= `RST_CMD;
    else if (start)
      cmd_ff <= (regWrData[7:0] == flash_pkg::CMD_NULL) ? `RST_CMD : regWrData[7:0];
    else if (done && op_ff <= flash_pkg::CMD_MASS)
      cmd_ff <= `RST_CMD;
  end

  // ----------------------------------------------------------------------
  // protection
  // ----------------------------------------------------------------------
  // written values, immediate mask reloaded with 0x0fffffff by system reset
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ppro_ff <= `RST_PPRO;
      ipro_ff <= `RST_IPRO;
    end
    else
    begin
      if (regWrite && regAddr == `OFS_PPRO)
        ppro_ff <= regWrData;
      if (regWrite && regAddr == `OFS_IPRO)
        ipro_ff <= regWrData;
    end
  end

  // saved value and key survive the system reset
  always_ff @(posedge clock)
  begin
    if (!powerOnRst_n)
    begin
      savedPro_ff <= `OPEN_PRO;
      savedKey_ff <= 32'h00000000;
      keySet_ff   <= 1'b0;
    end
    else if (done && op_ff == flash_pkg::CMD_PROTECT && result_ff)
    begin
      savedPro_ff <= ppro_ff;
      savedKey_ff <= keyIn;
      keySet_ff   <= 1'b1;
    end
    else if (done && op_ff == flash_pkg::CMD_MASS && result_ff)
    begin
      savedPro_ff <= `OPEN_PRO;
      keySet_ff   <= 1'b0;
    end
  end

  // saved value comes into force only at system reset
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      activePro_ff <= keySet_ff ? savedPro_ff : `OPEN_PRO;
    else
      activePro_ff <= activePro_ff;
  end

  // read lock when either mask clears bit 31
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      readLocked_ff <= 1'b1;
    else
      readLocked_ff <= !(activePro_ff[`PRO_READ] && ipro_ff[`PRO_READ]);
  end

  // ----------------------------------------------------------------------
  // status, set wins over read clear
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      irqPend_ff <= 1'b0;
      fail_ff    <= 1'b0;
      pass_ff    <= 1'b0;
    end
    else
    begin
      if (done && mode_ff[`MODE_IRQ_EN])
        irqPend_ff <= 1'b1;
      else if (statusRead)
        irqPend_ff <= 1'b0;
      if (done && !donePass)
        fail_ff <= 1'b1;
      else if (statusRead)
        fail_ff <= 1'b0;
      if (done && donePass)
        pass_ff <= 1'b1;
      else if (statusRead)
        pass_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdData_ff <= 32'h00000000;
    else if (regRead)
    begin
      unique case (regAddr)
        `OFS_STATUS: rdData_ff <= {28'h0000000, irqPend_ff,
                                   (state_ff != flash_pkg::ST_IDLE), fail_ff, pass_ff};
        `OFS_MODE:   rdData_ff <= {16'h0000, mode_ff};
        `OFS_CMD:    rdData_ff <= {24'h000000, cmd_ff};
        `OFS_DATA:   rdData_ff <= {16'h0000, data_ff};
        `OFS_ADDR:   rdData_ff <= {16'h0000, addr_ff};
        `OFS_SIGN:   rdData_ff <= {8'h00, sign_ff};
        `OFS_PPRO:   rdData_ff <= ppro_ff;
        `OFS_IPRO:   rdData_ff <= ipro_ff;
        default:     rdData_ff <= 32'h00000000;
      endcase
    end
    else
      rdData_ff <= 32'h00000000;
  end

  assign regRdData  = rdData_ff;
  assign flashIrq   = irqPend_ff;
  assign readLocked = readLocked_ff;
endmodule : flash_command_controller

// ---- sim/flash_command_controller_properties.sv ----
`timescale 1ns/1ps
`include "flash_cfg.svh"
module flash_command_controller_properties (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // register port
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdData,
  // status outputs
  input wire logic        flashIrq,
  input wire logic        readLocked
);
  logic irqEnFf;  // shadow of interrupt enable
  logic readOkFf; // shadow of immediate read permit
  wire  stRd = regRead && regAddr == `OFS_STATUS;
  wire  ping = regWrite && regAddr == `OFS_CMD && regWrData[7:0] == 8'h0f;
  // track the software view of mode and immediate protection
  always_ff @(posedge clock)
    if (!rst_n) irqEnFf <= 1'b0;
    else if (regWrite && regAddr == `OFS_MODE) irqEnFf <= regWrData[4];
  always_ff @(posedge clock)
    if (!rst_n) readOkFf <= 1'b0;
    else if (regWrite && regAddr == `OFS_IPRO) readOkFf <= regWrData[31];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !regRead |=> regRdData == 32'h0; endproperty
  property p_irq_clr; stRd ##1 !regRdData[2] |-> !flashIrq; endproperty
  property p_irq_en; $rose(flashIrq) |-> irqEnFf; endproperty
  property p_lock_set; regWrite && regAddr == `OFS_IPRO && !regWrData[31] |-> ##[1:2] readLocked;
  endproperty
  property p_lock_fall; $fell(readLocked) |-> readOkFf; endproperty
  property p_ping_busy; ping ##1 stRd |=> regRdData[2]; endproperty
  property p_ping_irq; ping && irqEnFf |-> ##[2:3] flashIrq; endproperty
  property p_ping_quiet; ping && !irqEnFf && !flashIrq |=> !flashIrq [*3]; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_irq_clr: assert property (p_irq_clr) else $error("irq kept after read");
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  a_lock_set: assert property (p_lock_set) else $error("read lock missing");
  a_lock_fall: assert property (p_lock_fall) else $error("read lock dropped");
  a_ping_busy: assert property (p_ping_busy) else $error("busy missing");
  a_ping_irq: assert property (p_ping_irq) else $error("ping irq missing");
  a_ping_quiet: assert property (p_ping_quiet) else $error("ping irq unmasked");
  c_ping_irq: cover property (ping && irqEnFf);
  c_lock_fall: cover property ($fell(readLocked));
  c_irq_read: cover property (stRd && flashIrq);
endmodule : flash_command_controller_properties
bind flash_command_controller flash_command_controller_properties chk (.clock(clock),
  .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .flashIrq(flashIrq), .readLocked(readLocked));

// ---- sim/flash_command_controller_tb.sv ----
`timescale 1ns/1ps
`include "flash_cfg.svh"
`define CMP(a, e) begin nCompared++; if ((a) !== (e)) begin nErrors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module flash_command_controller_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        powerOnRst_n = 1'b0;
  logic [31:0] regAddr = 32'h0;
  logic [31:0] regWrData = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdData;
  logic        flashIrq;
  logic        readLocked;
  logic [31:0] d;         // last read data
  int          polls;     // status polls of last command
  int          nErrors = 0;
  int          nCompared = 0;
  int          cycles = 0;
  always #2.5 clock = ~clock;
  // short timed commands, signature kept at full length
  flash_command_controller #(.WRITE_CYCLES(8), .EW_CYCLES(8), .MASS_CYCLES(8),
    .SIGN_CYCLES(32778)) dut (.clock(clock), .rst_n(rst_n), .powerOnRst_n(powerOnRst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .flashIrq(flashIrq), .readLocked(readLocked));
  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask : rd
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    `CMP(d, e)
  endtask : chk
  // start a command, read status at once, poll until idle
  task automatic run(input logic [7:0] c, input logic [3:0] e);
    @(posedge clock);
    regAddr <= `OFS_CMD;
    regWrData <= {24'h0, c};
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regAddr <= `OFS_STATUS;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 `CMP(regRdData[2], 1'b1)
    d = regRdData;
    for (polls = 0; polls < 20000 && d[2]; polls++) rd(`OFS_STATUS);
    `CMP(d[3:0], e)
  endtask : run
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk(`OFS_MODE, 32'h0);
    chk(`OFS_CMD, 32'h07);
    chk(`OFS_ADDR, 32'h0);
    chk(`OFS_SIGN, 32'h00ffffff);
    chk(`OFS_PPRO, 32'h0);
    chk(`OFS_IPRO, 32'h0fffffff);
    chk(`OFS_STATUS, 32'h0);
    chk(32'hfffff814, 32'h0);
    `CMP(readLocked, 1'b1)
    wr(`OFS_DATA, 32'ha5c3);
    chk(`OFS_DATA, 32'ha5c3);
    wr(`OFS_SIGN, 32'h123456);
    chk(`OFS_SIGN, 32'h00ffffff);
  endtask : t_reset
  task automatic t_prog;
    wr(`OFS_ADDR, 32'h0100);
    run(8'h02, 4'b0010);
    wr(`OFS_MODE, 32'h18);
    run(8'h05, 4'b1001);
    run(8'h01, 4'b1001);
    chk(`OFS_DATA, 32'hffff);
    wr(`OFS_DATA, 32'ha5c3);
    run(8'h02, 4'b1001);
    chk(`OFS_CMD, 32'h07);
    run(8'h04, 4'b1001);
    wr(`OFS_DATA, 32'h0);
    run(8'h04, 4'b1010);
    run(8'h01, 4'b1001);
    chk(`OFS_DATA, 32'ha5c3);
    wr(`OFS_ADDR, 32'h0102);
    run(8'h03, 4'b1001);
    wr(`OFS_ADDR, 32'h0100);
    run(8'h01, 4'b1001);
    chk(`OFS_DATA, 32'hffff);
  endtask : t_prog
  task automatic t_prot;
    wr(`OFS_IPRO, 32'h0ffffffe);
    wr(`OFS_ADDR, 32'h07fe);
    run(8'h05, 4'b1010);
    wr(`OFS_ADDR, 32'h0800);
    run(8'h05, 4'b1001);
    wr(`OFS_IPRO, 32'h8fffffff);
    repeat (3) @(posedge clock);
    `CMP(readLocked, 1'b0)
    wr(`OFS_IPRO, 32'h0fffffff);
  endtask : t_prot
  task automatic t_misc;
    logic [7:0] rsv[6] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};
    wr(`OFS_MODE, 32'h08);
    run(8'h0f, 4'b0001);
    chk(`OFS_CMD, 32'h0f);
    wr(`OFS_MODE, 32'h18);
    run(8'h0f, 4'b1001);
    wr(`OFS_CMD, 32'h00);
    chk(`OFS_STATUS, 32'h0);
    chk(`OFS_CMD, 32'h07);
    foreach (rsv[i])
    begin
      wr(`OFS_CMD, {24'h0, rsv[i]});
      chk(`OFS_STATUS, 32'h0);
      chk(`OFS_CMD, {24'h0, rsv[i]});
    end
  endtask : t_misc
  task automatic t_mass;
    wr(`OFS_DATA, 32'h0);
    wr(`OFS_ADDR, 32'hffc3);
    run(8'h06, 4'b1010);
    wr(`OFS_DATA, 32'h3cff);
    run(8'h06, 4'b1001);
    wr(`OFS_ADDR, 32'h0102);
    run(8'h01, 4'b1001);
    chk(`OFS_DATA, 32'hffff);
    run(8'h0b, 4'b1001);
    `CMP(polls, (`SIGN_CYCLES + 3) / 2)
  endtask : t_mass
  task automatic t_key;
    wr(`OFS_PPRO, 32'hfffffffd);
    wr(`OFS_MODE, 32'h48);
    wr(`OFS_ADDR, 32'h1234);
    wr(`OFS_DATA, 32'h5678);
    run(8'h0c, 4'b0001);
    wr(`OFS_MODE, 32'h08);
    wr(`OFS_ADDR, 32'h0800);
    run(8'h05, 4'b0001);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    chk(`OFS_PPRO, 32'h0);
    wr(`OFS_MODE, 32'h08);
    wr(`OFS_ADDR, 32'h0800);
    run(8'h05, 4'b0010);
  endtask : t_key
  // ----------------------------------------------------------------------
  // verdict and watchdog
  // ----------------------------------------------------------------------
  task automatic tallyAndFinish;
    $display("errors %0d compared %0d", nErrors, nCompared);
    if (nErrors == 0 && nCompared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tallyAndFinish
  // ceiling covers mass erase plus full-length signature, about 66k cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      nErrors++;
      tallyAndFinish();
    end
  end
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    powerOnRst_n <= 1'b1;
    t_reset();
    t_prog();
    t_prot();
    t_misc();
    t_mass();
    t_key();
    tallyAndFinish();
  end
endmodule : flash_command_controller_tb
